// File: rtl/pwci_params.svh
// Constants of the pulse-width configuration interface
`ifndef PWCI_PARAMS_SVH
`define PWCI_PARAMS_SVH
`define PWCI_CLK_PERIOD_NS 10
// Sample point after a rising edge: between 0.2 t and 0.8 t over 60..80 kHz
`define PWCI_SAMPLE_DELAY_NS 6000
`define PWCI_SAMPLE_DELAY_CYC (`PWCI_SAMPLE_DELAY_NS / `PWCI_CLK_PERIOD_NS)
`define PWCI_TIMEOUT_NS 16000
`define PWCI_TIMEOUT_CYC \
    ((`PWCI_TIMEOUT_NS + `PWCI_CLK_PERIOD_NS - 1) / `PWCI_CLK_PERIOD_NS)
`define PWCI_CODE_ENTRY 6'h0c
`define PWCI_CODE_READBACK 6'h3b
`define PWCI_SEL_JUMP 3'h7
`define PWCI_CMD_LOCK 11'h7f0
`define PWCI_CMD_NOLOCK 11'h755
`define PWCI_CMD_EXIT 11'h700
`define PWCI_RB_LAST 6'h3c
`define PWCI_WORD0_RST 8'h5c
`define PWCI_WORD1_RST 8'h5f
`define PWCI_WORD2_RST 8'h03
`define PWCI_WORD3_RST 8'h00
`define PWCI_WORD4_RST 8'h00
`define PWCI_WORD5_RST 8'h00
`endif

// File: rtl/pwci_pkg.sv
// Types of the pulse-width configuration interface
package pwci_pkg;
    typedef logic [5:0][7:0] pwci_words_t;
    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_PROG = 3'h1,
        ST_EE_LOCK = 3'h3,
        ST_EE_NOLOCK = 3'h2,
        ST_READBACK = 3'h4
    } pwci_state_t;
    typedef struct packed {
        logic [2:0] revision;
        logic [5:0] calibration;
        logic written;
        logic locked;
        pwci_words_t words;
    } pwci_nvm_t;
    typedef struct packed {
        logic active;
        logic data;
    } pwci_pair_t;
endpackage

// File: rtl/pwci_top.sv
// Single-pin pulse-width configuration interface, device end
// Function
// - Pattern 001100 in normal state enters programming state.
// - Word select 000,100,010,110,001,101 picks words 0..5, payload follows.
// - Word write length fixed; here three select plus eight payload bits.
// - After last bit the word is latched into working register at once.
// - One serial bit is taken per rising edge of the program pin.
// - Long idle gaps between word-write bits do not corrupt data.
// - Select 111 with unknown jump code returns to normal state.
// - 111 1111 0000 in state 2 enters EEPROM programming with lock.
// - 111 0101 0101 in state 2 enters EEPROM programming without lock.
// - 111 0000 0000 in state 3 or 4 returns to normal state.
// - Enable pin is ignored in states 2 to 5, no power-down.
// - Bit 0 is a short high pulse, bit 1 a long one.
// - Bit decoded by sampling the pin with a delayed copy of it.
// - During entry commands, an over-long high or low pulse aborts.
// - Host loads six words then jumps, waiting 10 ms to store.
// - Word writes alone change working registers, never the EEPROM.
// - Pin is write only; contents read back on the output pair.
// - Read-back: first edge loads, next edges shift 59 bits, 61st ends.
// - Stream: revision, calibration, written, lock, words 5..0 MSB first.
`include "pwci_params.svh"
`timescale 1ns/100ps
`default_nettype none

module pwci_top
    import pwci_pkg::*;
#(
    parameter int SAMPLE_DELAY_CYC = `PWCI_SAMPLE_DELAY_CYC,
    parameter int TIMEOUT_CYC = `PWCI_TIMEOUT_CYC
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Pins
    input wire logic serial_program_pin,
    input wire logic chip_enable_pin,
    // Non-volatile store
    input wire pwci_nvm_t nvm_contents,
    output logic nvm_prog_q,
    output logic nvm_lock_q,
    // Device side
    output pwci_words_t config_word_q,
    output logic power_down_q,
    output pwci_pair_t clock_output_pair
);

// ============================================================
// Pin synchronisers and pulse timing
logic pin_s1_q, pin_s2_q, pin_d_q, ce_s1_q, ce_s2_q;
logic rise, edge_any;
logic [10:0] pulse_cnt_q;
logic [10:0] dly_cnt_q;
logic dly_busy_q, bit_stb_q, bit_val_q;
pwci_state_t state_q;

always_ff @(posedge core_clk)
begin
    if (!resetn)
    begin
        pin_s1_q <= 1'b0;
        pin_s2_q <= 1'b0;
        pin_d_q <= 1'b0;
        ce_s1_q <= 1'b0;
        ce_s2_q <= 1'b0;
    end
    else if (clk_en)
    begin
        pin_s1_q <= serial_program_pin;
        pin_s2_q <= pin_s1_q;
        pin_d_q <= pin_s2_q;
        ce_s1_q <= chip_enable_pin;
        ce_s2_q <= ce_s1_q;
    end
end

assign rise = pin_s2_q & ~pin_d_q;
assign edge_any = pin_s2_q ^ pin_d_q;

// Saturating, so a stalled pin never wraps into a false short pulse
always_ff @(posedge core_clk)
begin
    if (!resetn)
        pulse_cnt_q <= 11'h000;
    else if (clk_en)
    begin
        if (edge_any)
            pulse_cnt_q <= 11'h000;
        else if (pulse_cnt_q != 11'(TIMEOUT_CYC))
            pulse_cnt_q <= pulse_cnt_q + 11'h001;
    end
end

// Delayed copy of the rising edge strobes the live pin level
always_ff @(posedge core_clk)
begin
    if (!resetn)
    begin
        dly_busy_q <= 1'b0;
        dly_cnt_q <= 11'h000;
        bit_stb_q <= 1'b0;
        bit_val_q <= 1'b0;
    end
    else if (clk_en)
    begin
        bit_stb_q <= 1'b0;
        if (rise)
        begin
            dly_busy_q <= 1'b1;
            dly_cnt_q <= 11'h001;
        end
        else if (dly_busy_q)
        begin
            if (dly_cnt_q == 11'(SAMPLE_DELAY_CYC))
            begin
                dly_busy_q <= 1'b0;
                bit_stb_q <= 1'b1;
                bit_val_q <= pin_s2_q;
            end
            else
                dly_cnt_q <= dly_cnt_q + 11'h001;
        end
    end
end

// ============================================================
// Command collection
logic [5:0] ent_sh_q, ent_next;
logic [2:0] ent_cnt_q;
logic [10:0] cmd_sh_q, cmd_next;
logic [3:0] cmd_cnt_q;
logic ent_done, cmd_done, timeout, in_cmd;
logic [2:0] wr_idx;
logic [7:0] wr_data;

assign ent_next = {ent_sh_q[4:0], bit_val_q};
assign cmd_next = {cmd_sh_q[9:0], bit_val_q};
assign in_cmd = state_q inside {ST_PROG, ST_EE_LOCK, ST_EE_NOLOCK};
assign ent_done = state_q == ST_NORMAL && bit_stb_q && ent_cnt_q == 3'h5;
assign cmd_done = in_cmd && bit_stb_q && cmd_cnt_q == 4'ha;
assign timeout = state_q == ST_NORMAL && ent_cnt_q != 3'h0 &&
    pulse_cnt_q == 11'(TIMEOUT_CYC);
// First select bit is the least significant
assign wr_idx = {cmd_next[8], cmd_next[9], cmd_next[10]};

always_comb
begin
    wr_data = 8'h00;
    for (int i = 0; i < 8; i++)
        wr_data[i] = cmd_next[7 - i];
end

always_ff @(posedge core_clk)
begin
    if (!resetn)
    begin
        ent_sh_q <= 6'h00;
        ent_cnt_q <= 3'h0;
    end
    else if (clk_en)
    begin
        if (timeout || ent_done || state_q != ST_NORMAL)
        begin
            ent_sh_q <= 6'h00;
            ent_cnt_q <= 3'h0;
        end
        else if (bit_stb_q)
        begin
            ent_sh_q <= ent_next;
            ent_cnt_q <= ent_cnt_q + 3'h1;
        end
    end
end

// No time-out here, so idle gaps between bits are harmless
always_ff @(posedge core_clk)
begin
    if (!resetn)
    begin
        cmd_sh_q <= 11'h000;
        cmd_cnt_q <= 4'h0;
    end
    else if (clk_en)
    begin
        if (!in_cmd || cmd_done)
        begin
            cmd_sh_q <= 11'h000;
            cmd_cnt_q <= 4'h0;
        end
        else if (bit_stb_q)
        begin
            cmd_sh_q <= cmd_next;
            cmd_cnt_q <= cmd_cnt_q + 4'h1;
        end
    end
end

// ============================================================
// State machine
logic [5:0] rb_cnt_q;

always_ff @(posedge core_clk)
begin
    if (!resetn)
        state_q <= ST_NORMAL;
    else if (clk_en)
    begin
        unique case (state_q)
            ST_NORMAL:
                if (ent_done && ent_next == `PWCI_CODE_ENTRY)
                    state_q <= ST_PROG;
                else if (ent_done && ent_next == `PWCI_CODE_READBACK)
                    state_q <= ST_READBACK;
            ST_PROG:
                if (cmd_done && cmd_next[10:8] == `PWCI_SEL_JUMP)
                begin
                    if (cmd_next == `PWCI_CMD_LOCK)
                        state_q <= ST_EE_LOCK;
                    else if (cmd_next == `PWCI_CMD_NOLOCK)
                        state_q <= ST_EE_NOLOCK;
                    else
                        state_q <= ST_NORMAL;
                end
            ST_EE_LOCK, ST_EE_NOLOCK:
                if (cmd_done && cmd_next[10:8] == `PWCI_SEL_JUMP)
                    state_q <= ST_NORMAL;
            ST_READBACK:
                if (rise && rb_cnt_q == `PWCI_RB_LAST)
                    state_q <= ST_NORMAL;
            default:
                state_q <= ST_NORMAL;
        endcase
    end
end

// ============================================================
// Working words and EEPROM requests
always_ff @(posedge core_clk)
begin
    if (!resetn)
        config_word_q <= {`PWCI_WORD5_RST, `PWCI_WORD4_RST,
            `PWCI_WORD3_RST, `PWCI_WORD2_RST, `PWCI_WORD1_RST,
            `PWCI_WORD0_RST};
    else if (clk_en && state_q == ST_PROG && cmd_done && wr_idx < 3'h6)
        config_word_q[wr_idx] <= wr_data;
end

// Only a jump stores; a locked store refuses the request
always_ff @(posedge core_clk)
begin
    if (!resetn)
    begin
        nvm_prog_q <= 1'b0;
        nvm_lock_q <= 1'b0;
    end
    else if (clk_en)
    begin
        nvm_prog_q <= 1'b0;
        if (state_q == ST_PROG && cmd_done && !nvm_contents.locked &&
            (cmd_next == `PWCI_CMD_LOCK || cmd_next == `PWCI_CMD_NOLOCK))
        begin
            nvm_prog_q <= 1'b1;
            nvm_lock_q <= cmd_next == `PWCI_CMD_LOCK;
        end
    end
end

always_ff @(posedge core_clk)
begin
    if (!resetn)
        power_down_q <= 1'b0;
    else if (clk_en)
        power_down_q <= state_q == ST_NORMAL && !ce_s2_q;
end

// ============================================================
// Read-back shifter
logic [58:0] rb_sh_q, rb_load;
logic [58:0] rb_msb;
pwci_pair_t pair_q;

assign rb_msb = {nvm_contents.revision, nvm_contents.calibration,
    nvm_contents.written, nvm_contents.locked, nvm_contents.words};

always_comb
begin
    rb_load = 59'h0;
    for (int i = 0; i < 59; i++)
        rb_load[i] = rb_msb[58 - i];
end

always_ff @(posedge core_clk)
begin
    if (!resetn)
    begin
        rb_cnt_q <= 6'h00;
        rb_sh_q <= 59'h0;
        pair_q <= '0;
    end
    else if (clk_en)
    begin
        if (state_q != ST_READBACK)
            rb_cnt_q <= 6'h00;
        else if (rise)
        begin
            rb_cnt_q <= rb_cnt_q + 6'h01;
            if (rb_cnt_q == 6'h00)
                rb_sh_q <= rb_load;
            else if (rb_cnt_q == `PWCI_RB_LAST)
                pair_q <= '0;
            else
            begin
                pair_q.active <= 1'b1;
                pair_q.data <= rb_sh_q[0];
                rb_sh_q <= {1'b0, rb_sh_q[58:1]};
            end
        end
    end
end

assign clock_output_pair = pair_q;

// ============================================================
// Assertions
// Eight quiet cycles are spent in the antecedent before the delay counts
localparam int SD_REST = SAMPLE_DELAY_CYC - 7;
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!resetn || !clk_en);

a_entry_prog: assert property (ent_done &&
    ent_next == `PWCI_CODE_ENTRY |=> state_q == ST_PROG)
    else $error("entry not taken");
a_entry_rdbk: assert property (ent_done &&
    ent_next == `PWCI_CODE_READBACK |=> state_q == ST_READBACK)
    else $error("readback not taken");
a_word_latch: assert property (state_q == ST_PROG && cmd_done &&
    wr_idx < 3'h6 |=> config_word_q[$past(wr_idx)] == $past(wr_data))
    else $error("word not latched");
a_words_hold: assert property (!(state_q == ST_PROG && cmd_done)
    |=> $stable(config_word_q)) else $error("word changed");
a_jump_lock: assert property (state_q == ST_PROG && cmd_done &&
    cmd_next == `PWCI_CMD_LOCK |=> state_q == ST_EE_LOCK)
    else $error("lock jump missed");
a_jump_nolock: assert property (state_q == ST_PROG && cmd_done &&
    cmd_next == `PWCI_CMD_NOLOCK |=> state_q == ST_EE_NOLOCK)
    else $error("nolock jump missed");
a_ee_exit: assert property (
    state_q inside {ST_EE_LOCK, ST_EE_NOLOCK} &&
    cmd_done && cmd_next == `PWCI_CMD_EXIT |=> state_q == ST_NORMAL)
    else $error("exit missed");
a_bad_jump: assert property (state_q == ST_PROG && cmd_done &&
    cmd_next[10:8] == `PWCI_SEL_JUMP && cmd_next != `PWCI_CMD_LOCK &&
    cmd_next != `PWCI_CMD_NOLOCK |=> state_q == ST_NORMAL)
    else $error("bad jump kept state");
a_ce_ignored: assert property (
    state_q != ST_NORMAL |=> !power_down_q)
    else $error("power down outside normal");
a_timeout_clear: assert property (timeout |=> ent_cnt_q == 3'h0 &&
    state_q == ST_NORMAL) else $error("timeout kept bits");
a_sample_delay: assert property (rise ##1 !rise [*8]
    |-> ##[SD_REST:SD_REST] bit_stb_q) else $error("sample late");
a_rb_end: assert property (state_q == ST_READBACK && rise &&
    rb_cnt_q == `PWCI_RB_LAST |=> state_q == ST_NORMAL && !pair_q.active)
    else $error("readback did not end");

c_prog: cover property (state_q == ST_NORMAL ##1 state_q == ST_PROG);
c_write: cover property (state_q == ST_PROG && cmd_done && wr_idx == 3'h5);
c_lock: cover property (state_q == ST_EE_LOCK ##1 state_q == ST_NORMAL);
c_rb: cover property (state_q == ST_READBACK ##1 state_q == ST_NORMAL);

endmodule

`default_nettype wire

// File: sim/pwci_host_model.sv
// Host model driving the pulse-width coded program pin
`timescale 1ns/100ps
`default_nettype none

module pwci_host_model
#(
    parameter int BIT_CYC = 50
)
(
    // Clock
    input wire logic core_clk,
    // Pin
    output logic serial_program_pin
);
    // ==========================================
    // Pulse shapes
    localparam int HI0 = BIT_CYC / 5;
    localparam int HI1 = BIT_CYC * 4 / 5;

    initial serial_program_pin = 1'b0;

    // Pin is driven low between bits, never left floating
    task automatic pulse(input int hi, input int lo);
        serial_program_pin <= 1'b1;
        repeat (hi) @(posedge core_clk);
        serial_program_pin <= 1'b0;
        repeat (lo) @(posedge core_clk);
    endtask

    // Leftmost bit of the pattern goes first
    task automatic send(input logic [10:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            if (bits[i])
                pulse(HI1, BIT_CYC - HI1);
            else
                pulse(HI0, BIT_CYC - HI0);
        end
    endtask
endmodule

`default_nettype wire

// File: sim/test_pwci_top.sv
// Self-checking bench of the pulse-width configuration interface
`timescale 1ns/100ps
`default_nettype none

module test_pwci_top
    import pwci_pkg::*;
;
    // ==========================================
    // Signals
    logic core_clk;
    logic resetn;
    logic clk_en;
    logic pin;
    logic ce;
    pwci_nvm_t nvm;
    logic prog;
    logic lock;
    pwci_words_t words;
    logic pd;
    pwci_pair_t pair;
    int bad_count;
    int compares;
    int prog_seen;
    logic lock_seen;
    pwci_words_t exp_w;

    // Short counts keep the 0.2t and 0.8t points around the sample delay
    pwci_top #(.SAMPLE_DELAY_CYC(20), .TIMEOUT_CYC(60)) dut
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .serial_program_pin(pin),
        .chip_enable_pin(ce),
        .nvm_contents(nvm),
        .nvm_prog_q(prog),
        .nvm_lock_q(lock),
        .config_word_q(words),
        .power_down_q(pd),
        .clock_output_pair(pair)
    );

    pwci_host_model #(.BIT_CYC(50)) host
    (
        .core_clk(core_clk),
        .serial_program_pin(pin)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (prog === 1'b1)
        begin
            prog_seen <= prog_seen + 1;
            lock_seen <= lock;
        end

    // ==========================================
    // Helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Select and payload both go least significant bit first
    function automatic logic [10:0] wcmd(input logic [2:0] w,
        input logic [7:0] v);
        logic [2:0] wr;
        logic [7:0] vr;
        wr = {<<{w}};
        vr = {<<{v}};
        return {wr, vr};
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic test_done;
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk(words, exp_w);
        chk({pd, pair, lock, prog_seen[0]}, 0);
    endtask

    task automatic t_powerdown;
        ce <= 1'b0;
        wait_cyc(10);
        chk(pd, 1'b1);
        ce <= 1'b1;
        wait_cyc(150);
        chk(pd, 1'b0);
    endtask

    task automatic t_program(input logic lk);
        logic [10:0] c;
        logic [7:0] v;
        int n;
        n = prog_seen;
        host.send(11'h00c, 6);
        ce <= 1'b0;
        for (int w = 0; w < 6; w++)
        begin
            v = (8'h11 * (w + 1)) ^ {7'h00, lk};
            c = wcmd(w, v);
            host.send(c >> 8, 3);
            // Gap far beyond the entry time-out
            wait_cyc(200);
            host.send(c, 8);
            exp_w[w] = v;
            chk(words, exp_w);
        end
        chk({pd, prog_seen}, {1'b0, n});
        host.send(lk ? 11'h7f0 : 11'h755, 11);
        chk({prog_seen, lock_seen}, {n + 1, lk});
        chk(pd, 1'b0);
        host.send(11'h700, 11);
        wait_cyc(10);
        chk({pd, words}, {1'b1, exp_w});
        ce <= 1'b1;
        wait_cyc(150);
    endtask

    task automatic t_badjump;
        host.send(11'h00c, 6);
        host.send(11'h733, 11);
        host.send(wcmd(0, 8'hff), 11);
        wait_cyc(100);
        chk(words, exp_w);
    endtask

    // A locked store must refuse a new programming request
    task automatic t_locked;
        int n;
        n = prog_seen;
        host.send(11'h00c, 6);
        host.send(11'h7f0, 11);
        wait_cyc(10);
        chk(prog_seen, n);
        host.send(11'h700, 11);
        wait_cyc(100);
        chk(words, exp_w);
    endtask

    task automatic t_timeout;
        host.send(11'h001, 3);
        // Low far beyond the time-out, bits must be dropped
        wait_cyc(100);
        host.send(11'h004, 3);
        host.send(wcmd(0, 8'hff), 11);
        wait_cyc(100);
        chk(words, exp_w);
    endtask

    task automatic t_readback;
        nvm <= {3'h5, 6'h2a, 1'b1, 1'b1, 48'h0123456789ab};
        host.send(11'h03b, 6);
        host.pulse(10, 40);
        for (int k = 0; k < 59; k++)
        begin
            host.pulse(10, 40);
            chk({pair.active, pair.data}, {1'b1, nvm[58 - k]});
        end
        host.pulse(10, 40);
        chk(pair.active, 1'b0);
        wait_cyc(100);
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        bad_count = 0;
        compares = 0;
        prog_seen = 0;
        lock_seen = 1'b0;
        resetn = 1'b0;
        clk_en = 1'b1;
        ce = 1'b1;
        nvm = '0;
        exp_w = {8'h00, 8'h00, 8'h00, 8'h03, 8'h5f, 8'h5c};
        wait_cyc(12);
        resetn <= 1'b1;
        wait_cyc(150);
        t_reset;
        t_powerdown;
        t_program(1'b1);
        t_program(1'b0);
        t_badjump;
        t_timeout;
        t_readback;
        t_locked;
        test_done;
    end

    // Whole run is near 20000 cycles
    initial
    begin
        wait_cyc(80000);
        bad_count++;
        test_done;
    end
endmodule

`default_nettype wire
